// [vcf_map.svh]
`ifndef VCF_MAP_SVH
`define VCF_MAP_SVH
// Summary of operation
// - ground key register written by command e8, read by e9; lsb selects read.
// - ground key low nibble is the per-channel filter sampling period in ms.
// - a zero sampling period disables the filter and passes input straight on.
// - host writes upper bits as zero; reads need not return zero there.
// - fir sections sum weighted delayed samples using shift-and-add products.
// - impedance and balance iir: output is input plus feedback times last output.
// - receive equalizer iir: first difference then single-pole recursion.
// - coefficient is n four-bit digits, sign in msb, three-bit shift code below.
// - shift code is an unsigned count of right shifts, 0 to 7.
// - first shift from binary point, later ones relative; signs multiply down.
// - digit position one is the most significant signed digit.
// - four digits in most filters, three in balance fir, two in post-gain.
// - transmit gain coefficient is one plus the decoded digit value.
// - transmit cutoff floats pcm output and strobe; beats both loopbacks.
// - receive cutoff zeroes receive signal before low-pass, blocking analog loop and tone.
// - high-pass bypass takes the transmit result around the single high-pass stage.
// - receive attenuate inserts a fixed extra loss in the receive path.
// - armed interrupt set on each new transmit sample, cleared by its read.
// - slot loopback returns received slot data on transmit slot.
// - analog loopback or entry code stops analog out and feeds rx to tx.
// - test signal inject replaces slot receive data with a milliwatt tone.
// - impedance filter and its iir run at a fixed sample rate.
// - transmit read returns two bytes, first the upper byte of the sample.

// ==========================================================
// command codes
`define VCF_CMD_GK_WR 8'he8
`define VCF_CMD_GK_RD 8'he9
`define VCF_CMD_TX_RD 8'hcd
`define VCF_RW_BIT 0
`define VCF_GK_MSB 3
`define VCF_GK_LSB 0
`define VCF_GK_RESET 4'h0
`define VCF_BYTE_ZERO 8'h00
`define VCF_IMP_ENTRY 5'h10

// ==========================================================
// timing, in ns and derived cycle counts at 125 MHz
`define VCF_CLK_NS 8
`define VCF_MS_NS 1000000
`define VCF_FS_NS 125000
`define VCF_ZFS_NS 31250
`define VCF_MS_CYC (`VCF_MS_NS / `VCF_CLK_NS)
`define VCF_FS_CYC (`VCF_FS_NS / `VCF_CLK_NS)
`define VCF_ZFS_CYC (`VCF_ZFS_NS / `VCF_CLK_NS)

// ==========================================================
// coefficient indices and digit counts
`define VCF_C_GX 4'd0
`define VCF_C_GR 4'd1
`define VCF_C_RF 4'd2
`define VCF_C_RI 4'd3
`define VCF_C_ZF 4'd4
`define VCF_C_ZI 4'd5
`define VCF_C_ZP 4'd6
`define VCF_C_BF 4'd7
`define VCF_C_BI 4'd8
`define VCF_NCOEF 9
`define VCF_N4 3'd4
`define VCF_N3 3'd3
`define VCF_N2 3'd2
`define VCF_COEF_RESET 16'h0000
`define VCF_HP_FB 16'h1700
`define VCF_ONE 20'h00400

// ==========================================================
// tone table, digital milliwatt at 8 samples per cycle
`define VCF_TONE_A 16'h2000
`define VCF_TONE_B 16'h16a1
`endif

// [vcf_pkg.sv]
package vcf_pkg;
	typedef enum logic [1:0] {
		VCF_IDLE = 2'b00,
		VCF_DATA = 2'b01,
		VCF_SEND2 = 2'b11
	} vcf_state_t;
	typedef logic signed [15:0] vcf_smp_t;
	typedef logic signed [19:0] vcf_acc_t;
endpackage

// [vcf_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "vcf_map.svh"

// ==========================================================
// fifo
module vcf_fifo #(
	parameter int W = 16,
	parameter int D = 16
) (
	input wire logic clk, // clock
	input wire logic rst_n, // async reset
	input wire logic in_valid, // push request
	output logic in_ready, // space available
	input wire logic [W-1:0] in_data, // push data
	output logic out_valid, // data available
	input wire logic out_ready, // pop request
	output logic [W-1:0] out_data // head word
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wp_q, rp_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (wp_q - rp_q) != (AW+1)'(D);
	assign out_valid = wp_q != rp_q;
	assign out_data = mem[rp_q[AW-1:0]];
	// storage has no reset; only pointers matter
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q[AW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_q + (AW+1)'(push);
			rp_q <= rp_q + (AW+1)'(pop);
		end
	end
endmodule

// ==========================================================
// voice channel top
module vcf_top import vcf_pkg::*; #(
	parameter int MS_CYC = `VCF_MS_CYC,
	parameter int FS_CYC = `VCF_FS_CYC
) (
	input wire logic mclk, // 125 MHz clock
	input wire logic arst_n, // async reset
	input wire logic cmd_valid, // command byte strobe
	input wire logic [7:0] cmd_byte, // command byte
	input wire logic data_valid, // write data strobe
	input wire logic [7:0] data_byte, // write data byte
	input wire logic [1:0] chan_sel, // addressed channel
	output logic rd_valid, // read byte strobe
	output logic [7:0] rd_byte, // read byte
	input wire logic coef_wr, // coefficient write
	input wire logic [3:0] coef_sel, // coefficient index
	input wire logic [15:0] coef_word, // four signed digits
	input wire logic transmit_cutoff, // test state bits
	input wire logic receive_cutoff, // zero rx path
	input wire logic highpass_bypass, // skip tx high-pass
	input wire logic receive_attenuate, // extra rx loss
	input wire logic transmit_irq_arm, // arm tx interrupt
	input wire logic slot_loopback, // rx slot to tx slot
	input wire logic analog_loopback, // rx out to tx in
	input wire logic receive_test_signal_inject, // tone
	input wire logic imp_scale_wr, // impedance scale write
	input wire logic [4:0] imp_scale_code, // scale code
	input wire logic [15:0] analog_in_pin, // converter sample
	input wire logic [15:0] slot_rx_data, // from slot assigner
	input wire logic slot_tick, // transmit slot time
	input wire logic [3:0] gk_in, // raw ground key inputs
	output logic [3:0] gk_out, // filtered ground key
	output logic [15:0] analog_out_pin, // to converter
	output logic analog_out_en, // converter drive on
	output logic impedance_scale_path, // scaling path on
	output logic [15:0] imp_feedback, // impedance filter out
	output logic [15:0] pcm_tx_out, // transmit slot data
	output logic pcm_tx_oe, // transmit drive enable
	output logic tx_slot_strobe_n, // slot strobe, low
	output logic tx_slot_strobe_oe, // strobe drive enable
	output logic tx_irq_n // transmit interrupt, low
);
	// shift-and-add product, innermost digit first
	function automatic vcf_acc_t csd_mul(input vcf_acc_t x,
		input logic [15:0] c, input logic [2:0] n);
		vcf_acc_t acc;
		acc = x;
		for (int k = 4; k >= 2; k--) begin
			if (3'(k) <= n) begin
				if (c[19-4*k]) acc = x - (acc >>> c[18-4*k -: 3]);
				else acc = x + (acc >>> c[18-4*k -: 3]);
			end
		end
		acc = acc >>> c[14:12];
		return c[15] ? -acc : acc;
	endfunction
	function automatic vcf_smp_t sat16(input vcf_acc_t v);
		if (v > 20'sh07fff) return 16'sh7fff;
		if (v < -20'sh08000) return -16'sh8000;
		return v[15:0];
	endfunction
	function automatic vcf_acc_t ext(input vcf_smp_t v);
		return {{4{v[15]}}, v};
	endfunction

	// ======================================================
	// rate dividers
	logic [16:0] ms_cnt_q, fs_cnt_q;
	logic [11:0] zs_cnt_q;
	wire ms_tick = ms_cnt_q == 17'(MS_CYC - 1);
	wire fs_tick = fs_cnt_q == 17'(FS_CYC - 1);
	wire zs_tick = zs_cnt_q == 12'(`VCF_ZFS_CYC - 1);
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ms_cnt_q <= '0;
			fs_cnt_q <= '0;
			zs_cnt_q <= '0;
		end else begin
			ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 17'd1;
			fs_cnt_q <= fs_tick ? '0 : fs_cnt_q + 17'd1;
			zs_cnt_q <= zs_tick ? '0 : zs_cnt_q + 12'd1;
		end
	end

	// ======================================================
	// coefficients: shadow written any time, active at boundary
	logic [15:0] coef_sh_q [`VCF_NCOEF];
	logic [15:0] coef_q [`VCF_NCOEF];
	generate
		for (genvar i = 0; i < `VCF_NCOEF; i++) begin : g_coef
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					coef_sh_q[i] <= `VCF_COEF_RESET;
					coef_q[i] <= `VCF_COEF_RESET;
				end else begin
					if (coef_wr && coef_sel == 4'(i)) begin
						coef_sh_q[i] <= coef_word;
					end
					if (fs_tick) begin
						coef_q[i] <= coef_sh_q[i];
					end
				end
			end
		end
	endgenerate

	// ======================================================
	// receive path at 8 kHz
	logic [2:0] tone_ph_q;
	logic signed [15:0] tone_mag;
	assign tone_mag = (tone_ph_q[1:0] == 2'd0) ? 16'sh0000 :
		(tone_ph_q[1:0] == 2'd2) ? `VCF_TONE_A : `VCF_TONE_B;
	wire vcf_smp_t tone = tone_ph_q[2] ? -tone_mag : tone_mag;
	wire vcf_smp_t rx_src = receive_test_signal_inject ? tone :
		slot_rx_data;
	// cutoff sits ahead of everything downstream, so tone and analog loop die; slot loopback takes slot_rx_data directly
	wire vcf_smp_t rx_cut = receive_cutoff ? 16'sh0000 : rx_src;
	wire vcf_smp_t rx_att = receive_attenuate ? (rx_cut >>> 1) :
		rx_cut;
	wire vcf_smp_t rx_g = sat16(csd_mul(ext(rx_att), coef_q[`VCF_C_GR],
		`VCF_N4));
	logic signed [15:0] rx_d1_q, rx_eq_in_q, rx_eq_q;
	// fir of two taps, then equalizer iir
	wire vcf_acc_t rx_fir = csd_mul(ext(rx_g), coef_q[`VCF_C_RF], `VCF_N4)
		+ csd_mul(ext(rx_d1_q), coef_q[`VCF_C_RF], `VCF_N4);
	wire vcf_smp_t rx_fir_s = sat16(rx_fir);
	wire vcf_smp_t rx_eq_d = sat16(ext(rx_fir_s) - ext(rx_eq_in_q)
		+ csd_mul(ext(rx_eq_q), coef_q[`VCF_C_RI], `VCF_N4));
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tone_ph_q <= '0;
			rx_d1_q <= '0;
			rx_eq_in_q <= '0;
			rx_eq_q <= '0;
		end else if (fs_tick) begin
			tone_ph_q <= tone_ph_q + 3'd1;
			rx_d1_q <= rx_g;
			rx_eq_in_q <= rx_fir_s;
			rx_eq_q <= rx_eq_d;
		end
	end

	// ======================================================
	// loopback entry and analog drive
	logic imp_entry_q;
	wire loop_on = analog_loopback || imp_entry_q;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			imp_entry_q <= 1'b0;
			analog_out_pin <= '0;
			analog_out_en <= 1'b0;
			impedance_scale_path <= 1'b0;
		end else begin
			if (imp_scale_wr) begin
				imp_entry_q <= imp_scale_code == `VCF_IMP_ENTRY;
			end
			analog_out_pin <= rx_eq_q;
			analog_out_en <= !loop_on;
			impedance_scale_path <= !loop_on;
		end
	end

	// ======================================================
	// impedance filter at 32 kHz
	logic signed [15:0] z_iir_q;
	wire vcf_smp_t z_src = loop_on ? 16'sh0000 : analog_in_pin;
	wire vcf_smp_t z_iir_d = sat16(ext(z_src)
		+ csd_mul(ext(z_iir_q), coef_q[`VCF_C_ZI], `VCF_N4));
	wire vcf_smp_t z_out = sat16(csd_mul(ext(z_src), coef_q[`VCF_C_ZF],
		`VCF_N4) + csd_mul(ext(z_iir_q), coef_q[`VCF_C_ZP], `VCF_N2));
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			z_iir_q <= '0;
			imp_feedback <= '0;
		end else if (zs_tick) begin
			z_iir_q <= z_iir_d;
			imp_feedback <= z_out;
		end
	end

	// ======================================================
	// transmit path at 8 kHz; balance path uses the cut rx signal
	logic signed [15:0] b_iir_q, hp_in_q, hp_q, tx_pend_d_q;
	logic tx_pend_q;
	wire vcf_smp_t b_iir_d = sat16(csd_mul(ext(rx_cut), coef_q[`VCF_C_BF],
		`VCF_N3) + csd_mul(ext(b_iir_q), coef_q[`VCF_C_BI],
		`VCF_N4));
	wire vcf_smp_t tx_src = loop_on ? rx_eq_q : analog_in_pin;
	wire vcf_smp_t tx_bal = sat16(ext(tx_src) - ext(b_iir_q));
	wire vcf_acc_t gx_prod = csd_mul(ext(tx_bal), coef_q[`VCF_C_GX],
		`VCF_N4);
	wire vcf_smp_t tx_g = sat16(ext(tx_bal) + gx_prod);
	wire vcf_smp_t hp_d = sat16(ext(tx_g) - ext(hp_in_q)
		+ csd_mul(ext(hp_q), `VCF_HP_FB, `VCF_N2));
	wire vcf_smp_t tx_res = highpass_bypass ? tx_g : hp_d;
	logic fifo_in_ready, fifo_out_valid;
	logic [15:0] fifo_out_data;
	// a full fifo holds the pending sample and freezes the tx high-pass; the balance iir keeps stepping
	wire tx_step = fs_tick && !tx_pend_q;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			b_iir_q <= '0;
			hp_in_q <= '0;
			hp_q <= '0;
			tx_pend_q <= 1'b0;
			tx_pend_d_q <= '0;
		end else begin
			if (fs_tick) begin
				b_iir_q <= b_iir_d;
			end
			if (tx_step) begin
				hp_in_q <= tx_g;
				hp_q <= hp_d;
				tx_pend_d_q <= tx_res;
				tx_pend_q <= 1'b1;
			end else if (fifo_in_ready) begin
				tx_pend_q <= 1'b0;
			end
		end
	end

	// ======================================================
	// transmit buffer, drained by slot times
	wire slot_pop = slot_tick && !transmit_cutoff;
	vcf_fifo #(.W(16), .D(16)) u_fifo (
		.clk(mclk),
		.rst_n(arst_n),
		.in_valid(tx_pend_q),
		.in_ready(fifo_in_ready),
		.in_data(tx_pend_d_q),
		.out_valid(fifo_out_valid),
		.out_ready(slot_pop),
		.out_data(fifo_out_data)
	);
	wire tx_new = slot_pop && fifo_out_valid;
	logic [15:0] tx_pcm_sample_q;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tx_pcm_sample_q <= '0;
			pcm_tx_out <= '0;
			pcm_tx_oe <= 1'b0;
			tx_slot_strobe_n <= 1'b1;
			tx_slot_strobe_oe <= 1'b0;
		end else begin
			if (tx_new) begin
				tx_pcm_sample_q <= fifo_out_data;
			end
			if (slot_pop) begin
				pcm_tx_out <= slot_loopback ? slot_rx_data :
					fifo_out_data;
			end
			pcm_tx_oe <= slot_pop;
			tx_slot_strobe_n <= !slot_pop;
			tx_slot_strobe_oe <= !transmit_cutoff;
		end
	end

	// ======================================================
	// ground key filters, one per channel
	logic [7:0] gk_reg_q [4];
	logic [3:0] gk_tick_q [4];
	logic [3:0] gk_smp_q;
	generate
		for (genvar c = 0; c < 4; c++) begin : g_gk
			wire [3:0] per = gk_reg_q[c][`VCF_GK_MSB:`VCF_GK_LSB];
			wire due = ms_tick && (gk_tick_q[c] + 4'd1 >= per);
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					gk_tick_q[c] <= '0;
					gk_smp_q[c] <= 1'b0;
					gk_out[c] <= 1'b0;
				end else if (per == `VCF_GK_RESET) begin
					gk_out[c] <= gk_in[c];
					gk_tick_q[c] <= '0;
				end else if (ms_tick) begin
					gk_tick_q[c] <= due ? 4'd0 : gk_tick_q[c] + 4'd1;
					if (due) begin
						gk_smp_q[c] <= gk_in[c];
						if (gk_smp_q[c] == gk_in[c]) begin
							gk_out[c] <= gk_in[c];
						end
					end
				end
			end
		end
	endgenerate

	// ======================================================
	// host command port
	vcf_state_t st_q;
	logic [7:0] cmd_q;
	wire cmd_read = cmd_byte[`VCF_RW_BIT];
	wire is_gk = cmd_byte[7:1] == 7'(`VCF_CMD_GK_WR >> 1);
	wire is_tx_rd = cmd_byte == `VCF_CMD_TX_RD;
	wire gk_write = st_q == VCF_DATA && data_valid
		&& cmd_q == `VCF_CMD_GK_WR;
	wire tx_read = st_q == VCF_IDLE && cmd_valid && is_tx_rd;
	generate
		for (genvar c = 0; c < 4; c++) begin : g_gkreg
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					gk_reg_q[c] <= {4'h0, `VCF_GK_RESET};
				end else if (gk_write && chan_sel == 2'(c)) begin
					gk_reg_q[c] <= data_byte;
				end
			end
		end
	endgenerate
	// sticky flag; a new sample in the read cycle still sets it
	logic tx_flag_q;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tx_flag_q <= 1'b0;
			tx_irq_n <= 1'b1;
		end else begin
			if (tx_new) begin
				tx_flag_q <= 1'b1;
			end else if (tx_read) begin
				tx_flag_q <= 1'b0;
			end
			tx_irq_n <= !(tx_flag_q && transmit_irq_arm);
		end
	end
	// one read byte per cycle; transmit read spills into a second
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= VCF_IDLE;
			cmd_q <= `VCF_BYTE_ZERO;
			rd_valid <= 1'b0;
			rd_byte <= `VCF_BYTE_ZERO;
		end else begin
			rd_valid <= 1'b0;
			case (st_q)
				VCF_IDLE: begin
					if (cmd_valid) begin
						cmd_q <= cmd_byte;
						if (tx_read) begin
							rd_valid <= 1'b1;
							rd_byte <= tx_pcm_sample_q[15:8];
							st_q <= VCF_SEND2;
						end else if (is_gk && cmd_read) begin
							rd_valid <= 1'b1;
							rd_byte <= gk_reg_q[chan_sel];
						end else if (is_gk) begin
							st_q <= VCF_DATA;
						end
					end
				end
				VCF_DATA: begin
					if (data_valid) begin
						st_q <= VCF_IDLE;
					end
				end
				VCF_SEND2: begin
					rd_valid <= 1'b1;
					rd_byte <= `VCF_BYTE_ZERO;
					st_q <= VCF_IDLE;
				end
				default: begin
					st_q <= VCF_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// [vcf_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker for the voice channel top
module vcf_top_chk (
	input wire logic mclk, // clock
	input wire logic arst_n, // async reset
	input wire logic cmd_valid, // command strobe
	input wire logic [7:0] cmd_byte, // command code
	input wire logic rd_valid, // read strobe
	input wire logic [7:0] rd_byte, // read byte
	input wire logic transmit_cutoff, // transmit cut off
	input wire logic slot_loopback, // slot loop
	input wire logic analog_loopback, // analog loop
	input wire logic transmit_irq_arm, // irq arm
	input wire logic imp_scale_wr, // scale write
	input wire logic [4:0] imp_scale_code, // scale code
	input wire logic [15:0] slot_rx_data, // slot data in
	input wire logic slot_tick, // slot time
	input wire logic analog_out_en, // converter drive
	input wire logic impedance_scale_path, // scaling on
	input wire logic [15:0] pcm_tx_out, // slot data out
	input wire logic pcm_tx_oe, // slot drive
	input wire logic tx_slot_strobe_n, // strobe
	input wire logic tx_slot_strobe_oe, // strobe drive
	input wire logic tx_irq_n // interrupt
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	// two-byte transmit read, second byte all zero
	sequence s_txrd_cmd;
		cmd_valid && cmd_byte == 8'hcd;
	endsequence
	sequence s_two_bytes;
		rd_valid ##1 (rd_valid && rd_byte == 8'h00) ##1 !rd_valid;
	endsequence
	a_txrd_two_bytes: assert property (s_txrd_cmd |=> s_two_bytes)
		else $error("transmit read reply malformed");
	a_gk_read_answer: assert property (cmd_valid && cmd_byte == 8'he9 |=> rd_valid)
		else $error("ground key read gave no byte");
	a_gk_write_silent: assert property (cmd_valid && cmd_byte == 8'he8 |=> !rd_valid [*2])
		else $error("ground key write returned a byte");
	// cutoff must beat every slot, loopback or not
	a_cutoff_no_slot: assert property (transmit_cutoff |=> !tx_slot_strobe_oe && !pcm_tx_oe)
		else $error("slot driven under cutoff");
	a_slot_drives_out: assert property (slot_tick && !transmit_cutoff |=> pcm_tx_oe && !tx_slot_strobe_n && tx_slot_strobe_oe)
		else $error("accepted slot not driven");
	a_slot_loop_data: assert property (slot_tick && slot_loopback && !transmit_cutoff |=> pcm_tx_out == $past(slot_rx_data))
		else $error("loop data differs from slot data");
	a_analog_loop_off: assert property (analog_loopback |=> !analog_out_en && !impedance_scale_path)
		else $error("analog loop left output on");
	// entry flag is registered ahead of the drive bit, so two edges
	a_entry_code_off: assert property (imp_scale_wr && imp_scale_code == 5'h10 |-> ##2 !analog_out_en)
		else $error("entry code left output on");
	// a read with no new sample in flight clears the line two edges on
	a_irq_read_clear: assert property (s_txrd_cmd and !slot_tick |-> ##2 tx_irq_n)
		else $error("interrupt not cleared by read");
	a_irq_unarmed_quiet: assert property (!transmit_irq_arm [*3] |-> tx_irq_n)
		else $error("interrupt raised while unarmed");
endmodule

bind vcf_top vcf_top_chk u_vcf_top_chk (.mclk, .arst_n, .cmd_valid, .cmd_byte,
	.rd_valid, .rd_byte, .transmit_cutoff, .slot_loopback, .analog_loopback,
	.transmit_irq_arm, .imp_scale_wr, .imp_scale_code, .slot_rx_data,
	.slot_tick, .analog_out_en, .impedance_scale_path, .pcm_tx_out,
	.pcm_tx_oe, .tx_slot_strobe_n, .tx_slot_strobe_oe, .tx_irq_n);
`default_nettype wire

// [vcf_hw_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// time-slot highway model
module vcf_hw_model (
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire logic run, // slots on
	input wire logic slow, // long slot spacing
	output logic slot_tick, // slot pulse
	output logic [15:0] slot_rx_data // receive slot word
);
	int gap = 0;
	initial slot_rx_data = 16'h5a3c;
	initial slot_tick = 1'b0;
	// data moves every cycle so a stale word on the loop path shows up
	always @(negedge clk) begin
		slot_tick <= 1'b0;
		slot_rx_data <= slot_rx_data + 16'h3b1d;
		if (!rst_n || !run)
			gap <= 0;
		else if (gap == 0) begin
			slot_tick <= 1'b1;
			gap <= slow ? 37 : 9;
		end else
			gap <= gap - 1;
	end
endmodule
`default_nettype wire

// [vcf_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench for the voice channel top
module vcf_top_tb_top;
	localparam int MS = 20;
	localparam int FS = 40;
	logic mclk, arst_n, cmd_valid, data_valid, rd_valid, coef_wr, imp_scale_wr;
	logic [7:0] cmd_byte, data_byte, rd_byte;
	logic [1:0] chan_sel;
	logic [3:0] coef_sel, gk_in, gk_out;
	logic [4:0] imp_scale_code;
	logic [15:0] coef_word, analog_in_pin, slot_rx_data, analog_out_pin;
	logic [15:0] imp_feedback, pcm_tx_out;
	logic transmit_cutoff, receive_cutoff, highpass_bypass, receive_attenuate;
	logic transmit_irq_arm, slot_loopback, analog_loopback, slot_tick, seen;
	logic receive_test_signal_inject, analog_out_en, impedance_scale_path;
	logic pcm_tx_oe, tx_slot_strobe_n, tx_slot_strobe_oe, tx_irq_n;
	logic slot_run, slot_slow;
	int n_mismatch = 0;
	int comparisons = 0;
	int seed = 14;
	int k;
	logic [7:0] exp_q[$];
	logic [7:0] msk_q[$];

	vcf_top #(.MS_CYC(MS), .FS_CYC(FS)) u_vcf_top (.mclk, .arst_n, .cmd_valid,
		.cmd_byte, .data_valid, .data_byte, .chan_sel, .rd_valid, .rd_byte,
		.coef_wr, .coef_sel, .coef_word, .transmit_cutoff, .receive_cutoff,
		.highpass_bypass, .receive_attenuate, .transmit_irq_arm, .slot_loopback,
		.analog_loopback, .receive_test_signal_inject, .imp_scale_wr,
		.imp_scale_code, .analog_in_pin, .slot_rx_data, .slot_tick, .gk_in,
		.gk_out, .analog_out_pin, .analog_out_en, .impedance_scale_path,
		.imp_feedback, .pcm_tx_out, .pcm_tx_oe, .tx_slot_strobe_n,
		.tx_slot_strobe_oe, .tx_irq_n);
	vcf_hw_model u_vcf_hw_model (.clk(mclk), .rst_n(arst_n), .run(slot_run),
		.slow(slot_slow), .slot_tick, .slot_rx_data);

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// converter samples change every cycle
	always @(negedge mclk) analog_in_pin <= 16'($random(seed));

	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic close_out();
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic timeout(input string what);
		n_mismatch++;
		$display("Error %s expected done seen timeout", what);
		close_out();
	endtask
	task automatic host_cmd(input logic [7:0] c, input logic [1:0] ch);
		@(negedge mclk);
		cmd_valid = 1'b1;
		cmd_byte = c;
		chan_sel = ch;
		@(negedge mclk);
		cmd_valid = 1'b0;
	endtask
	task automatic gk_write(input logic [1:0] ch, input logic [3:0] p);
		host_cmd(8'he8, ch);
		data_valid = 1'b1;
		data_byte = {4'h0, p};
		@(negedge mclk);
		data_valid = 1'b0;
	endtask
	// upper bits are masked off: reads need not return zero there
	task automatic gk_read(input logic [1:0] ch, input logic [3:0] p);
		exp_q.push_back({4'h0, p});
		msk_q.push_back(8'h0f);
		host_cmd(8'he9, ch);
	endtask
	task automatic tx_read();
		exp_q.push_back(8'h00);
		msk_q.push_back(8'h00);
		exp_q.push_back(8'h00);
		msk_q.push_back(8'hff);
		host_cmd(8'hcd, 2'd0);
		repeat (2) @(negedge mclk);
	endtask
	// read-byte watcher takes the oldest note for every byte that appears
	always @(negedge mclk) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0)
				chk("spare read byte", 16'h0, 16'h1);
			else begin
				chk("read byte", 16'(exp_q[0]), 16'(rd_byte & msk_q[0]));
				void'(exp_q.pop_front());
				void'(msk_q.pop_front());
			end
		end
	end

	initial begin
		{cmd_valid, data_valid, coef_wr, imp_scale_wr, slot_run, slot_slow} = '0;
		{cmd_byte, data_byte, chan_sel, coef_sel, gk_in, imp_scale_code} = '0;
		{transmit_cutoff, receive_cutoff, highpass_bypass, receive_attenuate} = '0;
		{transmit_irq_arm, slot_loopback, analog_loopback} = '0;
		receive_test_signal_inject = 1'b0;
		coef_word = 16'h0000;
		arst_n = 1'b0;
		repeat (20) @(posedge mclk);
		@(negedge mclk);
		arst_n = 1'b1;
		for (k = 0; k < 4; k++) gk_read(2'(k), 4'h0);
		for (k = 0; k < 4; k++) gk_write(2'(k), 4'(15 - 4 * k));
		for (k = 0; k < 4; k++) gk_read(2'(k), 4'(15 - 4 * k));
		gk_write(2'd0, 4'h0);
		gk_write(2'd1, 4'h2);
		gk_read(2'd0, 4'h0);
		// a zero period passes the input one cycle later
		@(negedge mclk);
		gk_in = 4'h3;
		@(negedge mclk);
		chk("unfiltered key", 16'h1, 16'(gk_out[0]));
		chk("filtered key early", 16'h0, 16'(gk_out[1]));
		for (k = 0; k < 400 && gk_out[1] !== 1'b1; k++) @(negedge mclk);
		if (k == 400) timeout("ground key filter");
		chk("filter delay reached", 16'h1, 16'(k >= 2 * MS));
		// coefficient writes, index 9 is out of range
		for (k = 0; k < 10; k++) begin
			@(negedge mclk);
			coef_wr = 1'b1;
			coef_sel = 4'(k);
			coef_word = 16'($random(seed));
		end
		@(negedge mclk);
		coef_wr = 1'b0;
		// armed interrupt: raised by a sample, held, cleared by the read
		transmit_irq_arm = 1'b1;
		slot_run = 1'b1;
		for (k = 0; k < 2000 && tx_irq_n !== 1'b0; k++) @(negedge mclk);
		if (k == 2000) timeout("transmit interrupt");
		slot_run = 1'b0;
		repeat (4) @(negedge mclk);
		chk("irq held", 16'h0, 16'(tx_irq_n));
		tx_read();
		chk("irq cleared", 16'h1, 16'(tx_irq_n));
		transmit_irq_arm = 1'b0;
		slot_slow = 1'b1;
		slot_run = 1'b1;
		slot_loopback = 1'b1;
		repeat (200) @(negedge mclk);
		chk("irq unarmed", 16'h1, 16'(tx_irq_n));
		// cutoff wins over loopback, fifo fills meanwhile
		transmit_cutoff = 1'b1;
		analog_loopback = 1'b1;
		seen = 1'b0;
		for (k = 0; k < 800; k++) begin
			@(negedge mclk);
			seen = seen | pcm_tx_oe | tx_slot_strobe_oe;
		end
		chk("cutoff drive", 16'h0, 16'(seen));
		chk("loop output off", 16'h0, 16'({analog_out_en, impedance_scale_path}));
		{transmit_cutoff, analog_loopback, slot_slow} = '0;
		repeat (2) @(negedge mclk);
		chk("loop output back", 16'h3, 16'({analog_out_en, impedance_scale_path}));
		for (k = 0; k < 2; k++) begin
			imp_scale_code = k ? 5'h01 : 5'h10;
			imp_scale_wr = 1'b1;
			@(negedge mclk);
			imp_scale_wr = 1'b0;
			repeat (2) @(negedge mclk);
			chk("entry code", 16'(k), 16'(analog_out_en));
		end
		// receive-side test bits and high-pass bypass in random mixes with slots running
		for (k = 0; k < 8; k++) begin
			{receive_cutoff, highpass_bypass, receive_attenuate} = 3'($random(seed));
			receive_test_signal_inject = 1'($random(seed));
			repeat (50) @(negedge mclk);
		end
		// digits 0808 nest to exactly zero, so both recursions must die out
		for (k = 3; k < 6; k += 2) begin
			@(negedge mclk);
			coef_wr = 1'b1;
			coef_sel = 4'(k);
			coef_word = 16'h0808;
		end
		@(negedge mclk);
		coef_wr = 1'b0;
		{receive_cutoff, analog_loopback} = 2'b11;
		repeat (9000) @(negedge mclk);
		chk("rx out under cutoff", 16'h0, analog_out_pin);
		chk("impedance out in loop", 16'h0, imp_feedback);
		for (k = 0; k < 100 && exp_q.size() != 0; k++) @(negedge mclk);
		if (k == 100) timeout("read bytes");
		close_out();
	end
endmodule
`default_nettype wire
